// ===== mmsc_pkg.sv
// Constants, register map and mode encodings for the multi-mode serial channel.
// Assumes a single 125 MHz clock and a plain strobe register port.
// Behaviour
// - Divider loaded with 00h wraps to FFh, 256 extra clocks, then undivided.
// - Polarity 0: drive on falling, sample rising, idle high; 1 swaps.
// - Synchronous mode, internal clock: transmit logic makes the clock for both directions.
// - Synchronous receive shifts dummy data out when tx pin is output.
// - Buffer still full at seventh bit of next character sets overrun.
// - Overrun character raises no receive interrupt request.
// - Mode 000 off, 001 sync, 100/101/110 async 7/8/9 bits.
package mmsc_pkg;
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_CTRL_A = 4'h1;
   localparam logic [3:0] ADDR_CTRL_B = 4'h2;
   localparam logic [3:0] ADDR_BAUD = 4'h3;
   localparam logic [3:0] ADDR_TXBUF = 4'h4;
   localparam logic [3:0] ADDR_RXBUF = 4'h5;
   localparam logic [3:0] ADDR_SPECIAL4 = 4'h6;
   localparam logic [3:0] ADDR_INT_STAT = 4'h7;
   localparam logic [3:0] ADDR_INT_MASK = 4'h8;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SYNC = 3'h1;
   localparam logic [2:0] MODE_ASYNC7 = 3'h4;
   localparam logic [2:0] MODE_ASYNC8 = 3'h5;
   localparam logic [2:0] MODE_ASYNC9 = 3'h6;
   // channel_control_a fields
   localparam int CA_CLKSEL_LO = 0;
   localparam int CA_CLKSEL_HI = 1;
   localparam int CA_POL = 2;
   localparam int CA_EXTCLK = 3;
   localparam int CA_TXPIN_OUT = 4;
   // channel_control_b fields
   localparam int CB_TE = 0;
   localparam int CB_TXEMPTY = 1;
   localparam int CB_RE = 2;
   localparam int CB_RXFULL = 3;
   // special_mode_control_4 fields
   localparam int S4_START = 0;
   localparam int S4_RESTART = 1;
   localparam int S4_STOP = 2;
   localparam int S4_CONDSEL = 3;
   // Interrupt status bits
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_OVR = 2;
   localparam int IRQ_W = 3;
   localparam int RX_OVR_BIT = 7;
   localparam int RX_OVR_POS = 15;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CTRL_B_RESET = 8'h02;
   localparam logic [3:0] CHAR_BITS_SYNC = 4'h8;
   localparam logic [3:0] CHAR_BITS_7 = 4'h7;
   localparam logic [3:0] CHAR_BITS_8 = 4'h8;
   localparam logic [3:0] CHAR_BITS_9 = 4'h9;
   localparam logic [3:0] OVR_BIT_CNT = 4'h7;
   localparam logic [1:0] PRE_DIV_1 = 2'h0;
   localparam logic [1:0] PRE_DIV_8 = 2'h1;
   localparam logic [1:0] PRE_DIV_32 = 2'h2;
   localparam logic [4:0] PRE_LIM_8 = 5'h07;
   localparam logic [4:0] PRE_LIM_32 = 5'h1F;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} mmsc_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mmsc_rx_e;
endpackage : mmsc_pkg

// ===== mmsc_baud.sv
// Baud divider counter for the serial channel.
// Assumes count_en is a one-cycle count source tick on clk.
`timescale 1ns/100ps
module mmsc_baud (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [7:0] div_value,
   input wire logic count_en,
   output logic tick
);
   logic [7:0] cnt_r;
   logic fresh_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fresh_r <= 1'b0;
      end else if (load) begin
         fresh_r <= 1'b1;
      end else if (count_en) begin
         fresh_r <= 1'b0;
      end
   end
   // A load only stores; reload occurs on underflow, so 00h wraps to FFh
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
      end else if (load) begin
         cnt_r <= div_value;
      end else if (count_en) begin
         if (cnt_r == 8'h00 && !fresh_r) begin
            cnt_r <= div_value;
         end else begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick <= 1'b0;
      end else begin
         tick <= count_en && !load && !fresh_r && (cnt_r == 8'h00);
      end
   end
endmodule : mmsc_baud

// ===== mmsc_channel.sv
// Top of the multi-mode serial channel: registers, transmit, receive, irq.
// Assumes one 125 MHz clock; pins are asynchronous and resynchronised here.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module mmsc_channel
   import mmsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic rx_data_pin,
   input wire logic sclk_in,
   output logic tx_data_pin,
   output logic tx_data_oe,
   output logic sclk_out,
   output logic sclk_oe,
   output logic cond_start,
   output logic cond_restart,
   output logic cond_stop,
   output logic irq
);
   import mmsc_pkg::*;

   logic [2:0] serial_mode_reg;
   logic [7:0] channel_control_a;
   logic te_r, re_r, tx_buffer_empty, rx_buffer_full;
   logic [7:0] baud_divider;
   logic [8:0] tx_buffer;
   logic [8:0] rx_buffer;
   logic overrun_flag;
   logic [3:0] special_mode_control_4;
   logic [IRQ_W-1:0] int_stat_r, int_mask_r;
   logic [2:0] rx_sync_r, ck_sync_r;
   logic [4:0] pre_r;
   logic pre_tick, baud_tick, baud_load;
   mmsc_tx_e tx_st_r;
   mmsc_rx_e rx_st_r;
   logic [8:0] tx_sh_r, rx_sh_r, rx_sh_nxt;
   logic [3:0] tx_cnt_r, rx_cnt_r, rx_ovs_r, tx_ovs_r;
   logic rx_lvl_r, ck_lvl_r, ck_prev_r;
   logic int_clk_r;
   logic [3:0] char_bits;
   logic is_sync, is_async, ext_clk, pol;
   logic clk_rise, clk_fall, drive_edge, sample_edge;
   logic ev_tx, ev_rx, ev_ovr;
   logic mode_wr_off, tx_load_go;

   wire logic wr_mode = wr && (addr == ADDR_MODE);
   wire logic wr_b = wr && (addr == ADDR_CTRL_B);
   wire logic wr_tb = wr && (addr == ADDR_TXBUF);
   wire logic rd_rb = rd && (addr == ADDR_RXBUF);

   assign is_sync = (serial_mode_reg == MODE_SYNC);
   assign is_async = (serial_mode_reg == MODE_ASYNC7) ||
                     (serial_mode_reg == MODE_ASYNC8) ||
                     (serial_mode_reg == MODE_ASYNC9);
   assign ext_clk = channel_control_a[CA_EXTCLK] && is_sync;
   assign pol = channel_control_a[CA_POL];
   assign mode_wr_off = wr_mode && (wdata[2:0] == MODE_OFF);

   always_comb begin
      char_bits = CHAR_BITS_SYNC;
      if (serial_mode_reg == MODE_ASYNC7) begin
         char_bits = CHAR_BITS_7;
      end else if (serial_mode_reg == MODE_ASYNC9) begin
         char_bits = CHAR_BITS_9;
      end else if (serial_mode_reg == MODE_ASYNC8) begin
         char_bits = CHAR_BITS_8;
      end
   end

   // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_sync_r <= 3'h7;
         ck_sync_r <= 3'h0;
         rx_lvl_r <= 1'b1;
         ck_lvl_r <= 1'b0;
         ck_prev_r <= 1'b0;
      end else begin
         rx_sync_r <= {rx_sync_r[1:0], rx_data_pin};
         ck_sync_r <= {ck_sync_r[1:0], sclk_in};
         if (rx_sync_r[1] == rx_sync_r[2]) begin
            rx_lvl_r <= rx_sync_r[2];
         end
         if (ck_sync_r[1] == ck_sync_r[2]) begin
            ck_lvl_r <= ck_sync_r[2];
         end
         ck_prev_r <= ck_lvl_r;
      end
   end

   // Count source prescaler selected by clock source select bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_r <= 5'h00;
      end else begin
         pre_r <= pre_r + 5'h01;
      end
   end
   always_comb begin
      pre_tick = 1'b1;
      if (channel_control_a[CA_CLKSEL_HI:CA_CLKSEL_LO] == PRE_DIV_8) begin
         pre_tick = (pre_r[2:0] == PRE_LIM_8[2:0]);
      end else if (channel_control_a[CA_CLKSEL_HI:CA_CLKSEL_LO] ==
                   PRE_DIV_32) begin
         pre_tick = (pre_r == PRE_LIM_32);
      end
   end
   assign baud_load = wr && (addr == ADDR_BAUD);

   mmsc_baud u_baud (
      .clk(clk),
      .rst(rst),
      .load(baud_load),
      .div_value(baud_load ? wdata[7:0] : baud_divider),
      .count_en(pre_tick),
      .tick(baud_tick)
   );

   // Register writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_mode_reg <= MODE_OFF;
         channel_control_a <= CTRL_A_RESET;
         baud_divider <= BAUD_RESET;
         special_mode_control_4 <= 4'h0;
         int_mask_r <= '0;
         te_r <= 1'b0;
         re_r <= 1'b0;
      end else begin
         if (wr_mode) begin
            serial_mode_reg <= wdata[2:0];
         end
         if (wr && addr == ADDR_CTRL_A) begin
            channel_control_a <= wdata[7:0];
         end
         if (baud_load) begin
            baud_divider <= wdata[7:0];
         end
         if (wr && addr == ADDR_SPECIAL4) begin
            special_mode_control_4 <= wdata[3:0];
         end
         if (wr && addr == ADDR_INT_MASK) begin
            int_mask_r <= wdata[IRQ_W-1:0];
         end
         if (wr_b) begin
            te_r <= wdata[CB_TE];
            re_r <= wdata[CB_RE];
         end
      end
   end

   // Condition requests pass to the bus side only when select bit is set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cond_start <= 1'b0;
         cond_restart <= 1'b0;
         cond_stop <= 1'b0;
      end else begin
         cond_start <= special_mode_control_4[S4_CONDSEL] &&
                       special_mode_control_4[S4_START];
         cond_restart <= special_mode_control_4[S4_CONDSEL] &&
                         special_mode_control_4[S4_RESTART];
         cond_stop <= special_mode_control_4[S4_CONDSEL] &&
                      special_mode_control_4[S4_STOP];
      end
   end

   // Internal serial clock from transmit control, also used to receive
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_clk_r <= 1'b1;
      end else if (!is_sync || !te_r || tx_st_r == TX_IDLE) begin
         int_clk_r <= !pol;
      end else if (baud_tick) begin
         int_clk_r <= !int_clk_r;
      end
   end
   assign clk_rise = ext_clk ? (ck_lvl_r && !ck_prev_r) :
                     (baud_tick && !int_clk_r && tx_st_r != TX_IDLE);
   assign clk_fall = ext_clk ? (!ck_lvl_r && ck_prev_r) :
                     (baud_tick && int_clk_r && tx_st_r != TX_IDLE);
   assign drive_edge = pol ? clk_rise : clk_fall;
   assign sample_edge = pol ? clk_fall : clk_rise;

   // Transmit sequencer; in sync mode it also runs for pure reception
   assign tx_load_go = te_r && !tx_buffer_empty;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 9'h1FF;
         tx_cnt_r <= 4'h0;
         tx_ovs_r <= 4'h0;
      end else if (mode_wr_off || !te_r) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 9'h1FF;
         tx_cnt_r <= 4'h0;
         tx_ovs_r <= 4'h0;
      end else begin
         case (tx_st_r)
            TX_IDLE: begin
               if (tx_load_go && (is_sync || is_async)) begin
                  tx_sh_r <= tx_buffer;
                  tx_cnt_r <= 4'h0;
                  tx_ovs_r <= 4'h0;
                  tx_st_r <= is_sync ? TX_DATA : TX_START;
               end
            end
            TX_START: begin
               if (baud_tick) begin
                  tx_ovs_r <= tx_ovs_r + 4'h1;
                  if (tx_ovs_r == OVS_LAST) begin
                     tx_st_r <= TX_DATA;
                  end
               end
            end
            TX_DATA: begin
               if (is_sync) begin
                  if (drive_edge && tx_cnt_r != 4'h0) begin
                     tx_sh_r <= {1'b1, tx_sh_r[8:1]};
                  end
                  if (sample_edge) begin
                     tx_cnt_r <= tx_cnt_r + 4'h1;
                     if (tx_cnt_r == char_bits - 4'h1) begin
                        tx_st_r <= TX_IDLE;
                     end
                  end
               end else if (baud_tick) begin
                  tx_ovs_r <= tx_ovs_r + 4'h1;
                  if (tx_ovs_r == OVS_LAST) begin
                     tx_sh_r <= {1'b1, tx_sh_r[8:1]};
                     tx_cnt_r <= tx_cnt_r + 4'h1;
                     if (tx_cnt_r == char_bits - 4'h1) begin
                        tx_st_r <= TX_STOP;
                     end
                  end
               end
            end
            TX_STOP: begin
               if (baud_tick) begin
                  tx_ovs_r <= tx_ovs_r + 4'h1;
                  if (tx_ovs_r == OVS_LAST) begin
                     tx_st_r <= TX_IDLE;
                  end
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // Buffer empty flag: set when loaded into shifter, cleared by buffer write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_buffer <= 9'h000;
         tx_buffer_empty <= 1'b1;
      end else if (wr_tb) begin
         tx_buffer <= wdata[8:0];
         tx_buffer_empty <= 1'b0;
      end else if (tx_st_r == TX_IDLE && tx_load_go && !mode_wr_off &&
                   (is_sync || is_async)) begin
         tx_buffer_empty <= 1'b1;
      end
   end
   assign ev_tx = tx_st_r == TX_IDLE && tx_load_go && !mode_wr_off &&
                  (is_sync || is_async) && te_r;

   // Pin drive; start bit low, then LSB first; sync receive sends the transmit buffer contents as dummy data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_data_pin <= 1'b1;
         tx_data_oe <= 1'b0;
         sclk_out <= 1'b1;
         sclk_oe <= 1'b0;
      end else begin
         tx_data_pin <= (tx_st_r == TX_START) ? 1'b0 :
                        (tx_st_r == TX_DATA) ? tx_sh_r[0] : 1'b1;
         tx_data_oe <= channel_control_a[CA_TXPIN_OUT] &&
                       (is_sync || is_async);
         sclk_out <= int_clk_r;
         sclk_oe <= is_sync && !channel_control_a[CA_EXTCLK];
      end
   end

   always_comb begin
      rx_sh_nxt = {2'b00, rx_lvl_r, rx_sh_r[6:1]};
      if (char_bits == CHAR_BITS_9) begin
         rx_sh_nxt = {rx_lvl_r, rx_sh_r[8:1]};
      end else if (char_bits == CHAR_BITS_8) begin
         rx_sh_nxt = {1'b0, rx_lvl_r, rx_sh_r[7:1]};
      end
   end

   // Receive sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_st_r <= RX_IDLE;
         rx_sh_r <= 9'h000;
         rx_cnt_r <= 4'h0;
         rx_ovs_r <= 4'h0;
      end else if (mode_wr_off || !re_r) begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= 4'h0;
         rx_ovs_r <= 4'h0;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               rx_cnt_r <= 4'h0;
               rx_ovs_r <= 4'h0;
               if (is_sync) begin
                  rx_st_r <= RX_DATA;
               end else if (is_async && !rx_lvl_r) begin
                  rx_st_r <= RX_START;
               end
            end
            RX_START: begin
               if (baud_tick) begin
                  rx_ovs_r <= rx_ovs_r + 4'h1;
                  if (rx_ovs_r == OVS_MID) begin
                     rx_ovs_r <= 4'h0;
                     rx_st_r <= rx_lvl_r ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (is_sync ? sample_edge :
                   (baud_tick && rx_ovs_r == OVS_LAST)) begin
                  rx_sh_r <= rx_sh_nxt;
                  rx_cnt_r <= rx_cnt_r + 4'h1;
                  if (rx_cnt_r == char_bits - 4'h1) begin
                     rx_st_r <= is_sync ? RX_IDLE : RX_STOP;
                  end
               end
               if (!is_sync && baud_tick) begin
                  rx_ovs_r <= rx_ovs_r + 4'h1;
               end
            end
            RX_STOP: begin
               if (baud_tick) begin
                  rx_ovs_r <= rx_ovs_r + 4'h1;
                  if (rx_ovs_r == OVS_LAST) begin
                     rx_st_r <= RX_IDLE;
                  end
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   logic rx_bit_take, rx_done, ovr_hit, ovr_pend_r;
   assign rx_bit_take = rx_st_r == RX_DATA && re_r && !mode_wr_off &&
                        (is_sync ? sample_edge :
                         (baud_tick && rx_ovs_r == OVS_LAST));
   assign rx_done = rx_bit_take && (rx_cnt_r == char_bits - 4'h1);
   assign ovr_hit = rx_bit_take && (rx_cnt_r == OVR_BIT_CNT - 4'h1) &&
                    rx_buffer_full;

   // Receive buffer, full flag and overrun; set wins over clear by read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_buffer <= 9'h000;
         rx_buffer_full <= 1'b0;
         overrun_flag <= 1'b0;
         ovr_pend_r <= 1'b0;
      end else begin
         if (ovr_hit) begin
            overrun_flag <= 1'b1;
            ovr_pend_r <= 1'b1;
         end else if (mode_wr_off) begin
            overrun_flag <= 1'b0;
            ovr_pend_r <= 1'b0;
         end
         if (rx_done) begin
            rx_buffer <= rx_sh_nxt;
            rx_buffer_full <= 1'b1;
            ovr_pend_r <= 1'b0;
         end else if (rd_rb) begin
            rx_buffer_full <= 1'b0;
         end
      end
   end
   assign ev_rx = rx_done && !ovr_pend_r && !ovr_hit;
   assign ev_ovr = ovr_hit;

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_stat_r <= '0;
      end else begin
         int_stat_r <= (int_stat_r &
                        ~((wr && addr == ADDR_INT_STAT) ?
                          wdata[IRQ_W-1:0] : '0)) |
                       {ev_ovr, ev_rx, ev_tx};
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   // Read port, data one cycle after strobe; unmapped reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         if (addr == ADDR_MODE) begin
            rdata <= {13'h0000, serial_mode_reg};
         end else if (addr == ADDR_CTRL_A) begin
            rdata <= {8'h00, channel_control_a};
         end else if (addr == ADDR_CTRL_B) begin
            rdata <= {12'h000, rx_buffer_full, re_r, tx_buffer_empty, te_r};
         end else if (addr == ADDR_BAUD) begin
            rdata <= {8'h00, baud_divider};
         end else if (addr == ADDR_TXBUF) begin
            rdata <= {7'h00, tx_buffer};
         end else if (addr == ADDR_RXBUF) begin
            rdata <= {overrun_flag, 6'h00, rx_buffer};
         end else if (addr == ADDR_SPECIAL4) begin
            rdata <= {12'h000, special_mode_control_4};
         end else if (addr == ADDR_INT_STAT) begin
            rdata <= {13'h0000, int_stat_r};
         end else if (addr == ADDR_INT_MASK) begin
            rdata <= {13'h0000, int_mask_r};
         end else begin
            rdata <= 16'h0000;
         end
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule : mmsc_channel

// ===== mmsc_properties.sv
// Port-level checks for the serial channel top.
// Assumes it is bound to mmsc_channel and sees only its ports.
`timescale 1ns/100ps
module mmsc_properties
   import mmsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic tx_data_pin,
   input wire logic tx_data_oe,
   input wire logic sclk_oe,
   input wire logic cond_start,
   input wire logic cond_restart,
   input wire logic cond_stop,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_RDATA_IDLE:
      assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside the answer cycle");
   AST_UNMAPPED:
      assert property (rd && addr > ADDR_INT_MASK |=> rdata == 16'h0000)
      else $error("unmapped read returned nonzero data");
   AST_START:
      assert property (wr && addr == ADDR_SPECIAL4 && wdata[3:0] == 4'h9
         |=> ##1 cond_start) else $error("start condition not raised");
   AST_RESTART:
      assert property (wr && addr == ADDR_SPECIAL4 && wdata[3:0] == 4'hA
         |=> ##1 cond_restart) else $error("restart condition not raised");
   AST_STOP:
      assert property (wr && addr == ADDR_SPECIAL4 && wdata[3:0] == 4'hC
         |=> ##1 cond_stop) else $error("stop condition not raised");
   AST_NO_COND:
      assert property (wr && addr == ADDR_SPECIAL4 && !wdata[S4_CONDSEL]
         |=> ##1 !(cond_start || cond_restart || cond_stop))
      else $error("condition raised while select is clear");
   AST_MASK_OFF:
      assert property (wr && addr == ADDR_INT_MASK && wdata == 16'h0000
         |=> ##1 !irq) else $error("interrupt high with all masked");
   AST_MODE_OFF:
      assert property (wr && addr == ADDR_MODE && wdata[2:0] == MODE_OFF
         |=> ##1 tx_data_pin && !tx_data_oe && !sclk_oe)
      else $error("pins not idle after channel disabled");
endmodule : mmsc_properties

bind mmsc_channel mmsc_properties u_props (.clk(clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .tx_data_pin(tx_data_pin), .tx_data_oe(tx_data_oe), .sclk_oe(sclk_oe),
   .cond_start(cond_start), .cond_restart(cond_restart),
   .cond_stop(cond_stop), .irq(irq));

// ===== mmsc_remote.sv
// Remote asynchronous serial device on the far side of the link.
// Assumes BIT clocks per bit, matching the channel's divider setting.
`timescale 1ns/100ps
module mmsc_remote #(
   parameter int BIT = 32
) (
   input wire logic clk,
   input wire logic tx_data_pin,
   output logic rx_data_pin,
   output logic sclk_in
);
   initial begin
      rx_data_pin = 1'b1;
      sclk_in = 1'b1;
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_data_pin <= f[i];
         repeat (BIT) @(posedge clk);
      end
   endtask : send
   task automatic recv(output logic [7:0] b);
      @(negedge tx_data_pin);
      // Land in the middle of the first data bit
      repeat (BIT + BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = tx_data_pin;
         repeat (BIT) @(posedge clk);
      end
   endtask : recv
endmodule : mmsc_remote

// ===== mmsc_channel_tb.sv
// Self-checking bench for the serial channel: registers, link, irq.
// Assumes the remote model drives the far end of the link.
`timescale 1ns/100ps
module mmsc_channel_tb;
   import mmsc_pkg::*;
   localparam int LIMIT = 20000;
   localparam int DIV = 1;
   localparam int BIT = 16 * (DIV + 1);
   localparam logic [2:0] MODES [5] = '{MODE_OFF, MODE_SYNC,
      MODE_ASYNC7, MODE_ASYNC8, MODE_ASYNC9};
   localparam logic [3:0] CONDS [4] = '{4'h9, 4'hA, 4'hC, 4'h7};
   logic clk, rst, wr, rd, tx_data_pin, tx_data_oe, sclk_out, sclk_oe;
   logic cond_start, cond_restart, cond_stop, irq, rx_data_pin, sclk_in;
   logic [3:0] addr;
   logic [15:0] wdata, rdata;
   logic [7:0] pv, rb;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   assign pv = {irq, sclk_oe, sclk_out, tx_data_oe, tx_data_pin,
      cond_stop, cond_restart, cond_start};
   always #4 clk = ~clk;
   mmsc_channel dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rx_data_pin(rx_data_pin),
      .sclk_in(sclk_in), .tx_data_pin(tx_data_pin),
      .tx_data_oe(tx_data_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .cond_start(cond_start), .cond_restart(cond_restart),
      .cond_stop(cond_stop), .irq(irq));
   mmsc_remote #(.BIT(BIT)) rem (.clk(clk), .tx_data_pin(tx_data_pin),
      .rx_data_pin(rx_data_pin), .sclk_in(sclk_in));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
      input logic [15:0] m = 16'hFFFF);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      cmp(rdata & m, e);
   endtask : rd_chk
   // Pins are looked at mid-cycle, once the edge's updates have landed
   task automatic pin_chk(input logic [7:0] e, input logic [7:0] m);
      @(negedge clk);
      cmp({8'h00, pv & m}, {8'h00, e});
      @(posedge clk);
   endtask : pin_chk
   task automatic wait_irq();
      for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
   endtask : wait_irq
   task automatic complete_run();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(ADDR_CTRL_A, {8'h00, CTRL_A_RESET});
      rd_chk(ADDR_CTRL_B, {8'h00, CTRL_B_RESET});
      rd_chk(ADDR_BAUD, {8'h00, BAUD_RESET});
      wr_reg(4'hA, 16'hFFFF);
      rd_chk(4'hA, 16'h0000);
      foreach (MODES[i]) begin
         wr_reg(ADDR_MODE, {13'h0000, MODES[i]});
         rd_chk(ADDR_MODE, {13'h0000, MODES[i]});
      end
      foreach (CONDS[i]) begin
         wr_reg(ADDR_SPECIAL4, 16'h0000);
         wr_reg(ADDR_SPECIAL4, {12'h000, CONDS[i]});
         pin_chk({5'h00, CONDS[i][3] ? CONDS[i][2:0] : 3'h0}, 8'h07);
      end
      wr_reg(ADDR_MODE, {13'h0000, MODE_OFF});
      wr_reg(ADDR_CTRL_A, 16'h0010);
      wr_reg(ADDR_BAUD, DIV[15:0]);
      wr_reg(ADDR_MODE, {13'h0000, MODE_ASYNC8});
      wr_reg(ADDR_INT_MASK, 16'h0007);
      wr_reg(ADDR_CTRL_B, 16'h0005);
      // The divider was loaded with DIV, so it ticks every DIV+1 counts with no wrap
      repeat (300) @(posedge clk);
      rem.send(8'hA5);
      wait_irq();
      rd_chk(ADDR_CTRL_B, 16'h000F);
      rd_chk(ADDR_INT_STAT, 16'h0002);
      rd_chk(ADDR_RXBUF, 16'h00A5);
      wr_reg(ADDR_INT_STAT, 16'h0002);
      pin_chk(8'h00, 8'h80);
      rem.send(8'h11);
      wait_irq();
      wr_reg(ADDR_INT_STAT, 16'h0002);
      rem.send(8'h22);
      wait_irq();
      rd_chk(ADDR_INT_STAT, 16'h0004);
      rd_chk(ADDR_RXBUF, 16'h8000, 16'h8000);
      wr_reg(ADDR_CTRL_B, 16'h0000);
      wr_reg(ADDR_MODE, {13'h0000, MODE_OFF});
      rd_chk(ADDR_RXBUF, 16'h0000, 16'h8000);
      wr_reg(ADDR_MODE, {13'h0000, MODE_ASYNC8});
      wr_reg(ADDR_CTRL_B, 16'h0005);
      wr_reg(ADDR_INT_STAT, 16'h0007);
      fork
         rem.recv(rb);
         wr_reg(ADDR_TXBUF, 16'h003C);
      join
      cmp({8'h00, rb}, 16'h003C);
      rd_chk(ADDR_INT_STAT, 16'h0001, 16'h0001);
      wr_reg(ADDR_CTRL_B, 16'h0001);
      repeat (BIT) @(posedge clk);
      wr_reg(ADDR_INT_STAT, 16'h0007);
      rem.send(8'h5A);
      repeat (BIT) @(posedge clk);
      rd_chk(ADDR_INT_STAT, 16'h0000);
      rd_chk(ADDR_CTRL_B, 16'h0003);
      wr_reg(ADDR_MODE, {13'h0000, MODE_SYNC});
      pin_chk(8'h78, 8'h78);
      wr_reg(ADDR_CTRL_A, 16'h0014);
      @(posedge clk);
      pin_chk(8'h58, 8'h78);
      wr_reg(ADDR_CTRL_A, 16'h0018);
      pin_chk(8'h10, 8'h50);
      wr_reg(ADDR_CTRL_A, 16'h0010);
      wr_reg(ADDR_BAUD, 16'h0000);
      wr_reg(ADDR_CTRL_B, 16'h0005);
      wr_reg(ADDR_TXBUF, 16'h0000);
      repeat (200) @(posedge clk);
      rd_chk(ADDR_CTRL_B, 16'h0000, 16'h0008);
      repeat (100) @(posedge clk);
      rd_chk(ADDR_RXBUF, 16'h00FF);
      pin_chk(8'h80, 8'h80);
      wr_reg(ADDR_MODE, {13'h0000, MODE_OFF});
      pin_chk(8'h08, 8'h58);
      wr_reg(ADDR_INT_MASK, 16'h0000);
      pin_chk(8'h00, 8'h80);
      complete_run();
   end
endmodule : mmsc_channel_tb
